// ### rtl/sqs_pkg.sv
// Constants, types and helpers for the sequencer channel select block.
package sqs_pkg;
   localparam int SQS_LAYERS = 32;         // Sequencer stack depth.
   localparam int SQS_DEFAULTS = 8;        // Layers preset to input pairs.
   localparam int SQS_LW = 5;              // Layer index width.
   localparam int SQS_LAY_W = 9;           // Stored bits of one layer.
   localparam int SQS_AW = 6;              // Register address width.
   localparam int SQS_DW = 16;             // Data word width.
   localparam int SQS_FINAL_BIT = 8;       // Final layer flag position.
   localparam int SQS_B_LSB = 4;           // Bank B select position.
   localparam int SQS_A_LSB = 0;           // Bank A select position.
   localparam int SQS_STAT_A_LSB = 12;     // Status bank A index position.
   localparam int SQS_STAT_B_LSB = 8;      // Status bank B index position.
   localparam int SQS_CFG_STAT_BIT = 0;    // Status append enable position.
   localparam int SQS_CFG_CRC_BIT = 1;     // Checksum enable position.
   localparam int SQS_SPACE_BIT = 5;       // Address bit that leaves layers.
   localparam logic [5:0] SQS_CFG_ADDR = 6'h20;  // Configuration register.
   localparam logic [5:0] SQS_STAT_ADDR = 6'h21; // Readout status word.
   localparam logic [3:0] SQS_SEL_SUPPLY = 4'h8;    // Supply monitor.
   localparam logic [3:0] SQS_SEL_REGULATOR = 4'h9; // Regulator output.
   localparam logic [3:0] SQS_SEL_SELF_TEST = 4'hB; // Interface self test.
   localparam logic [15:0] SQS_PAT_A = 16'hAAAA; // Self test word, bank A.
   localparam logic [15:0] SQS_PAT_B = 16'h5555; // Self test word, bank B.
   localparam logic [7:0] SQS_CRC_POLY = 8'h07;  // Checksum polynomial.
   localparam logic [7:0] SQS_CRC_INIT = 8'h00;  // Checksum start value.

   // Readout states.
   typedef enum logic [1:0] {SQS_IDLE, SQS_WORD_A, SQS_WORD_B,
      SQS_STATUS} sqs_state_e;

   // Whole state of the block.
   typedef struct packed {
      logic [SQS_LAYERS-1:0][SQS_LAY_W-1:0] layer; // Sequencer stack.
      logic cfg_status;                 // Status append enable.
      logic cfg_crc;                    // Checksum enable.
      logic [SQS_LW-1:0] cur;           // Current layer.
      sqs_state_e st;                   // Readout state.
      logic [SQS_DW-1:0] res_b;         // Held bank B word.
      logic [SQS_DW-1:0] out_data;      // Word shown to the reader.
      logic [SQS_DW-1:0] status;        // Readout status word.
      logic [7:0] crc_acc;              // Running checksum.
      logic [SQS_DW-1:0] rdata;         // Register read data.
   } sqs_state_s;

   // Checksum of one 16-bit word, most significant bit first.
   function automatic logic [7:0] sqs_crc8(input logic [7:0] c,
      input logic [SQS_DW-1:0] w);
      logic [7:0] r;
      r = c;
      for (int i = SQS_DW - 1; i >= 0; i--)
      begin
         r = (r[7] ^ w[i]) ? ({r[6:0], 1'b0} ^ SQS_CRC_POLY)
            : {r[6:0], 1'b0};
      end
      return r;
   endfunction

   // Reset image: first layers walk the input pairs, the rest are zero.
   function automatic sqs_state_s sqs_reset_value();
      sqs_state_s s;
      s = '0;
      s.st = SQS_IDLE;
      s.crc_acc = SQS_CRC_INIT;
      for (int i = 0; i < SQS_DEFAULTS; i++)
      begin
         s.layer[i] = {1'b0, 4'(i), 4'(i)};
      end
      return s;
   endfunction

   localparam sqs_state_s SQS_RESET = sqs_reset_value(); // Reset state.
endpackage

// ### rtl/sqs_channel_select.sv
// Sequencer channel selection, result readout and status word.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sqs_channel_select
   import sqs_pkg::*;
(
   input wire logic CLK_SYS,                  // System clock, 40 MHz.
   input wire logic RESET,                    // Asynchronous reset, high.
   input wire logic [SQS_AW-1:0] REG_ADDR,    // Register word address.
   input wire logic [SQS_DW-1:0] REG_WDATA,   // Register write data.
   input wire logic REG_WR,                   // Register write strobe.
   input wire logic REG_RD,                   // Register read strobe.
   output logic [SQS_DW-1:0] REG_RDATA,       // Read data, next cycle.
   input wire logic CONV_DONE,                // Converter pair finished.
   input wire logic [SQS_DW-1:0] CONV_RESULT_A, // Bank A result.
   input wire logic [SQS_DW-1:0] CONV_RESULT_B, // Bank B result.
   output logic CONV_READY,                   // Ready for a new pair.
   output logic [3:0] CH_SEL_A,               // Bank A input select.
   output logic [3:0] CH_SEL_B,               // Bank B input select.
   input wire logic WORD_RD,                  // Reader takes the word.
   output logic WORD_VALID,                   // A word is waiting.
   output logic [SQS_DW-1:0] WORD_DATA        // Word being offered.
);
   sqs_state_s q;                  // Registered state.
   sqs_state_s d;                  // Next state.
   logic [SQS_LAY_W-1:0] cur_lay;  // Current layer contents.
   logic lay_final;                // Current layer ends the sequence.
   logic append;                   // Status word is appended.
   logic [SQS_DW-1:0] word_a;      // Bank A word after self test.
   logic [SQS_DW-1:0] word_b;      // Bank B word after self test.
   logic [SQS_LW-1:0] next_layer;  // Layer after the current one.
   logic capture;                  // A converter pair is taken.

   // Current layer decode; codes pass unchanged to the input muxes.
   assign cur_lay = q.layer[q.cur];
   assign lay_final = cur_lay[SQS_FINAL_BIT];
   assign append = q.cfg_status | q.cfg_crc;
   assign capture = CONV_DONE && (q.st == SQS_IDLE);

   assign CH_SEL_A = cur_lay[SQS_A_LSB +: 4];
   assign CH_SEL_B = cur_lay[SQS_B_LSB +: 4];

   assign word_a = (CH_SEL_A == SQS_SEL_SELF_TEST) ? SQS_PAT_A
      : CONV_RESULT_A;
   assign word_b = (CH_SEL_B == SQS_SEL_SELF_TEST) ? SQS_PAT_B
      : CONV_RESULT_B;

   assign next_layer = lay_final ? '0 : SQS_LW'(q.cur + 1'b1);

   // Next state: register port, then readout sequence.
   always_comb
   begin
      d = q;
      d.rdata = '0;
      // Writes to layers and configuration; the status word ignores them.
      if (REG_WR)
      begin
         if (!REG_ADDR[SQS_SPACE_BIT])
         begin
            d.layer[REG_ADDR[SQS_LW-1:0]] = REG_WDATA[SQS_LAY_W-1:0];
         end
         else if (REG_ADDR == SQS_CFG_ADDR)
         begin
            d.cfg_status = REG_WDATA[SQS_CFG_STAT_BIT];
            d.cfg_crc = REG_WDATA[SQS_CFG_CRC_BIT];
         end
      end
      // Reads answer one cycle later; unmapped addresses read zero.
      if (REG_RD)
      begin
         if (!REG_ADDR[SQS_SPACE_BIT])
         begin
            d.rdata = SQS_DW'(q.layer[REG_ADDR[SQS_LW-1:0]]);
         end
         else if (REG_ADDR == SQS_CFG_ADDR)
         begin
            d.rdata = '0;
            d.rdata[SQS_CFG_STAT_BIT] = q.cfg_status;
            d.rdata[SQS_CFG_CRC_BIT] = q.cfg_crc;
         end
         else if (REG_ADDR == SQS_STAT_ADDR)
         begin
            d.rdata = q.status;
         end
      end
      // Readout: word A, word B, then status at the end of the sequence if status or checksum is enabled.
      case (q.st)
         SQS_IDLE:
         begin
            if (CONV_DONE)
            begin
               d.out_data = word_a;
               d.res_b = word_b;
               d.crc_acc = sqs_crc8(sqs_crc8(q.crc_acc, word_a), word_b);
               d.status[SQS_STAT_A_LSB +: 4] = CH_SEL_A;
               d.status[SQS_STAT_B_LSB +: 4] = CH_SEL_B;
               d.status[7:0] = d.crc_acc;
               d.st = SQS_WORD_A;
            end
         end
         SQS_WORD_A:
         begin
            // Bank B word follows bank A.
            if (WORD_RD)
            begin
               d.out_data = q.res_b;
               d.st = SQS_WORD_B;
            end
         end
         SQS_WORD_B:
         begin
            if (WORD_RD)
            begin
               // self test words also precede status
               if (lay_final && append)
               begin
                  d.out_data = q.status;
                  d.st = SQS_STATUS;
               end
               else
               begin
                  d.cur = next_layer;
                  d.st = SQS_IDLE;
               end
            end
         end
         SQS_STATUS:
         begin
            // Status taken: checksum restarts for the next sequence.
            if (WORD_RD)
            begin
               d.crc_acc = SQS_CRC_INIT;
               d.cur = next_layer;
               d.st = SQS_IDLE;
            end
         end
         default:
         begin
            d.st = SQS_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge CLK_SYS or posedge RESET)
   begin
      if (RESET)
      begin
         q <= SQS_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs come from the state flops.
   assign REG_RDATA = q.rdata;
   assign WORD_DATA = q.out_data;
   assign WORD_VALID = (q.st != SQS_IDLE);
   assign CONV_READY = (q.st == SQS_IDLE);

   // Pair taken, then both words read out.
   sequence seq_capture;
      capture;
   endsequence
   sequence seq_last_b;
      (q.st == SQS_WORD_B) && WORD_RD && lay_final;
   endsequence

   a_self_test_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_capture and (CH_SEL_A == SQS_SEL_SELF_TEST) |=>
      WORD_VALID && (WORD_DATA == SQS_PAT_A))
      else $error("self test A pattern wrong");
   // bank B self test word
   // The held bank B word is checked, so a stalling reader still counts.
   a_self_test_b: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_capture and (CH_SEL_B == SQS_SEL_SELF_TEST) |=>
      (q.res_b == SQS_PAT_B))
      else $error("self test B pattern wrong");
   a_status_ro: assert property (@(posedge CLK_SYS) disable iff (RESET)
      REG_WR && !capture |=> $stable(q.status))
      else $error("status word changed by a write");
   a_status_last: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_last_b and append |=> WORD_VALID && (WORD_DATA == q.status)
      ##0 (q.st == SQS_STATUS))
      else $error("status word not appended");
   a_no_status: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_last_b and !append |=> !WORD_VALID)
      else $error("status word appended while disabled");
   a_status_after_test: assert property (@(posedge CLK_SYS)
      disable iff (RESET) seq_last_b and append
      and (CH_SEL_A == SQS_SEL_SELF_TEST) |=> (q.st == SQS_STATUS))
      else $error("status word missing after self test");
   a_index_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_capture |=> q.status[SQS_STAT_A_LSB +: 4] == $past(CH_SEL_A))
      else $error("status bank A index wrong");
   a_index_b: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_capture |=> q.status[SQS_STAT_B_LSB +: 4] == $past(CH_SEL_B))
      else $error("status bank B index wrong");
   a_crc_byte: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_capture |=> q.status[7:0] == sqs_crc8(sqs_crc8($past(q.crc_acc),
      $past(word_a)), $past(word_b)))
      else $error("status checksum wrong");
   a_loop_back: assert property (@(posedge CLK_SYS) disable iff (RESET)
      seq_last_b and !append |=> (q.cur == '0))
      else $error("sequencer did not loop back");
   a_advance: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (q.st == SQS_WORD_B) && WORD_RD && !lay_final |=>
      (q.cur == SQS_LW'($past(q.cur) + 1'b1)))
      else $error("sequencer did not advance");
endmodule
`default_nettype wire

// ### verif/sqs_host_model.sv
// Host model that takes readout words with an adjustable stall.
`timescale 1ns/1ps
`default_nettype none
module sqs_host_model
(
   input wire logic clk,              // System clock.
   input wire logic rst,              // Reset, active high.
   input wire logic [3:0] gap,        // Stall cycles before a take.
   input wire logic word_valid,       // A word is offered.
   input wire logic [15:0] word_data, // Offered word.
   output logic word_rd,              // One-cycle take strobe.
   output logic took,                 // A word was taken last edge.
   output logic [15:0] took_data      // The word that was taken.
);
   logic [3:0] wait_cnt; // Stall cycles spent on the current word.

   // Waits the stall, then holds the strobe for exactly one edge.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         word_rd <= 1'b0;
         wait_cnt <= 4'h0;
         took <= 1'b0;
         took_data <= 16'h0000;
      end
      else
      begin
         took <= word_rd && word_valid;
         took_data <= word_data;
         word_rd <= !word_rd && word_valid && wait_cnt >= gap;
         if (word_valid && !word_rd && wait_cnt < gap)
            wait_cnt <= wait_cnt + 4'h1;
         else
            wait_cnt <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// ### verif/sqs_channel_select_test.sv
// Self-checking bench for the sequencer channel select block.
`timescale 1ns/1ps
`default_nettype none
module sqs_channel_select_test;
   import sqs_pkg::*;
   logic clk_sys, reset, reg_wr, reg_rd, conv_done, conv_ready; // Controls.
   logic word_rd, word_valid, took; // Readout handshake.
   logic [5:0] reg_addr; // Register address.
   logic [15:0] reg_wdata, reg_rdata, conv_result_a, conv_result_b; // Data.
   logic [15:0] word_data, took_data, last_stat; // Readout words.
   logic [3:0] ch_sel_a, ch_sel_b, gap; // Selects and host stall.
   logic [7:0] crc_acc; // Expected checksum so far.
   int miscompares = 0; // Mismatches seen.
   int cmp_count = 0; // Comparisons made.

   sqs_channel_select u_dut (.CLK_SYS(clk_sys), .RESET(reset),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CONV_DONE(conv_done),
      .CONV_RESULT_A(conv_result_a), .CONV_RESULT_B(conv_result_b),
      .CONV_READY(conv_ready), .CH_SEL_A(ch_sel_a), .CH_SEL_B(ch_sel_b),
      .WORD_RD(word_rd), .WORD_VALID(word_valid), .WORD_DATA(word_data));
   sqs_host_model u_host (.clk(clk_sys), .rst(reset), .gap(gap),
      .word_valid(word_valid), .word_data(word_data), .word_rd(word_rd),
      .took(took), .took_data(took_data));

   // Free-running 40 MHz clock.
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Bitwise CRC-8, polynomial 0x07, most significant bit first.
   function automatic logic [7:0] crc8(input logic [7:0] c,
      input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      return c;
   endfunction

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read; data is looked at in the following cycle.
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask

   // Compares both input selects once they have settled.
   task automatic sel(input logic [3:0] a, input logic [3:0] b);
      #1 chk({8'h00, ch_sel_a, ch_sel_b}, {8'h00, a, b});
   endtask

   // Waits for the host to take a word, then compares it.
   task automatic getw(input logic [15:0] e);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      while (took !== 1'b1 && n < 100);
      chk({15'h0000, took}, 16'h0001);
      chk(took_data, e);
   endtask

   // Feeds one result pair and checks every word that it yields.
   task automatic pair(input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] ea, input logic [15:0] eb, input logic st,
      input logic [7:0] idx);
      @(posedge clk_sys);
      conv_done <= 1'b1;
      conv_result_a <= a;
      conv_result_b <= b;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      conv_result_a <= ~a;
      conv_result_b <= ~b;
      #1 chk({14'h0, word_valid, conv_ready}, 16'h0002);
      getw(ea);
      crc_acc = crc8(crc_acc, ea);
      getw(eb);
      crc_acc = crc8(crc_acc, eb);
      if (st)
      begin
         last_stat = {idx, crc_acc};
         getw(last_stat);
         crc_acc = 8'h00;
      end
      #1 chk({14'h0, word_valid, conv_ready}, 16'h0001);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #(25 * 20000);
      miscompares++;
      end_sim();
   end

   // Main sequence of register accesses and conversions.
   initial
   begin
      {reset, reg_wr, reg_rd, conv_done, reg_addr} = {4'h8, 6'h00};
      {reg_wdata, conv_result_a, conv_result_b} = '0;
      {gap, crc_acc, last_stat} = '0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd(6'(i), {8'h00, 4'(i), 4'(i)});
      rd(6'h08, 16'h0000);
      rd(SQS_STAT_ADDR, 16'h0000);
      rd(6'h3F, 16'h0000);
      wr(SQS_CFG_ADDR, 16'h0001);
      wr(6'h00, 16'h0121);
      sel(4'h1, 4'h2);
      pair(16'h1111, 16'h2222, 16'h1111, 16'h2222, 1'b1, 8'h12);
      rd(SQS_STAT_ADDR, last_stat);
      wr(SQS_STAT_ADDR, 16'hFFFF);
      rd(SQS_STAT_ADDR, last_stat);
      sel(4'h1, 4'h2);
      wr(SQS_CFG_ADDR, 16'h0002);
      wr(6'h00, 16'h01BB);
      gap <= 4'h3;
      pair(16'h1234, 16'h4321, 16'hAAAA, 16'h5555, 1'b1, 8'hBB);
      wr(SQS_CFG_ADDR, 16'h0000);
      wr(6'h00, 16'h0000);
      gap <= 4'h0;
      pair(16'h0F0F, 16'hF0F0, 16'h0F0F, 16'hF0F0, 1'b0, 8'h00);
      sel(4'h1, 4'h1);
      for (int k = 0; k < 12; k++)
         if (k != 10) // Reserved code skipped
         begin
            wr(6'h01, {8'h00, 4'(k), 4'(k)});
            sel(4'(k), 4'(k));
         end
      wr(6'h01, 16'hFE11);
      rd(6'h01, 16'h0011);
      pair(16'h00FF, 16'hFF00, 16'h00FF, 16'hFF00, 1'b0, 8'h00);
      rd(SQS_STAT_ADDR, {8'h11, crc_acc});
      sel(4'h2, 4'h2);
      end_sim();
   end
endmodule
`default_nettype wire
